// ### logic/lofpc_pkg.sv
package lofpc_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] LOFPC_LED_FORCE_IDX = 6'h18;
  localparam logic [5:0] LOFPC_XCVR_CTRL_IDX = 6'h19;

  // led_force_control field positions
  localparam int LOFPC_ACT_VAL_BIT = 0;
  localparam int LOFPC_LNK_VAL_BIT = 1;
  localparam int LOFPC_SPD_VAL_BIT = 2;
  localparam int LOFPC_OVR_EN_LSB = 3;
  localparam int LOFPC_LED_FIELD_W = 6;

  // transceiver_control field positions
  localparam int LOFPC_AUTO_X_BIT = 15;
  localparam int LOFPC_FORCE_X_BIT = 14;
  localparam int LOFPC_PAUSE_RX_BIT = 13;
  localparam int LOFPC_PAUSE_TX_BIT = 12;
  localparam int LOFPC_INJECT_BIT = 11;
  localparam int LOFPC_LONG_SEQ_BIT = 10;
  localparam int LOFPC_PASS_BIT = 9;
  localparam int LOFPC_RUN_BIT = 8;
  localparam int LOFPC_BYPASS_BIT = 7;

  // reset values
  localparam logic [5:0] LOFPC_LED_FORCE_RST = 6'h00;
  localparam logic [14:0] LOFPC_PRBS_SEED = 15'h0001;

  // strap is sampled once its two-stage synchroniser has filled
  localparam logic [1:0] LOFPC_STRAP_WAIT = 2'h2;

  // led pulse stretch time and its cycle count at the core clock
  localparam int LOFPC_CLK_MHZ = 200;
  localparam int LOFPC_LED_STRETCH_MS = 50;
  localparam int LOFPC_STRETCH_CYC = LOFPC_LED_STRETCH_MS * LOFPC_CLK_MHZ * 1000;
  localparam int LOFPC_STRETCH_W = 24;

  // received bits before the checker starts comparing
  localparam logic [4:0] LOFPC_FILL_LONG = 5'h10;
  localparam logic [4:0] LOFPC_FILL_SHORT = 5'h0a;

  typedef enum logic [1:0] {
    LOFPC_BIST_IDLE,
    LOFPC_BIST_FILL,
    LOFPC_BIST_CHECK
  } lofpc_bist_e;

  // internal status indications, index 0 act, 1 link, 2 speed
  typedef struct packed {
    logic speed_100;
    logic link_good;
    logic activity;
  } lofpc_ind_s;

  // negotiation results; ability pairs are {asym_dir, pause}
  typedef struct packed {
    logic [1:0] local_ability_reg;
    logic [1:0] partner_ability_reg;
    logic full_duplex;
    logic auto_swap_req;
  } lofpc_an_s;

  typedef struct packed {
    logic [5:0] led;
    logic auto_x;
    logic force_x;
    logic inject;
    logic long_seq;
    logic run;
    logic bypass;
    logic fail;
    logic pass;
    logic [1:0] strap_cnt;
    logic strap_s1;
    logic strap_s2;
    lofpc_bist_e bst;
    logic [4:0] fill;
    logic [14:0] gen;
    logic [14:0] chk;
    logic tx_bit;
    logic [2:0][LOFPC_STRETCH_W-1:0] str_cnt;
    logic [2:0] led_out;
    logic cross_sel;
    logic pause_rx;
    logic pause_tx;
    logic wr_led;
    logic wr_ctl;
    logic [15:0] rdata;
  } lofpc_state_s;

endpackage

// ### logic/lofpc_regs.sv
`timescale 1ns/1ps

// Behaviour
// - speed override enable drives speed value
// - link override enable drives link value
// - activity override enable drives activity value
// - upper led bits ignore writes, read zero
// - led register reads stored values only
// - strap-reset bit enables automatic crossover
// - force bit crosses the pairs
// - pause receive resolved, full duplex only
// - pause transmit resolved, full duplex only
// - inject bit adds one error while the self-test is out of idle, self-clears
// - pass flag; failure latched until stop
// - bypass skips led pulse stretching
module lofpc_regs
  import lofpc_pkg::*;
#(
  parameter int unsigned STRETCH_CYCLES = LOFPC_STRETCH_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // transceiver status
  input wire lofpc_ind_s ind,
  input wire lofpc_an_s an,
  input wire logic auto_crossover_strap,
  // led pins
  output logic speed_led_out,
  output logic link_led_out,
  output logic activity_collision_led_out,
  // transceiver control
  output logic crossover_sel,
  output logic pause_rx_en,
  output logic pause_tx_en,
  output logic selftest_tx_bit
);

  lofpc_state_s s_ff;
  lofpc_state_s nxt_s;

  logic addr_ok;
  logic [15:0] wdat;
  logic [2:0] raw;
  logic gen_fb;
  logic chk_fb;
  logic lp;
  logic la;
  logic rp;
  logic ra;
  logic [4:0] fill_max;
  logic stretched;
  logic drive;

  // only whole-word single transfers are issued, so hsize is not decoded
  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  assign wdat = hwdata[15:0];
  assign raw = ind;
  assign lp = an.local_ability_reg[0];
  assign la = an.local_ability_reg[1];
  assign rp = an.partner_ability_reg[0];
  assign ra = an.partner_ability_reg[1];

  // zero wait states, never an error
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {16'h0000, s_ff.rdata};

  assign speed_led_out = s_ff.led_out[2];
  assign link_led_out = s_ff.led_out[1];
  assign activity_collision_led_out = s_ff.led_out[0];
  assign crossover_sel = s_ff.cross_sel;
  assign pause_rx_en = s_ff.pause_rx;
  assign pause_tx_en = s_ff.pause_tx;
  assign selftest_tx_bit = s_ff.tx_bit;

  always_comb begin
    nxt_s = s_ff;
    gen_fb = 1'b0;
    chk_fb = 1'b0;
    fill_max = LOFPC_FILL_SHORT;
    stretched = 1'b0;
    drive = 1'b0;

    // strap pin: two flops, then caught once after reset release
    nxt_s.strap_s1 = auto_crossover_strap;
    nxt_s.strap_s2 = s_ff.strap_s1;
    // count one past the fill so the catch below happens only once
    if (s_ff.strap_cnt != LOFPC_STRAP_WAIT + 2'h1) begin
      nxt_s.strap_cnt = s_ff.strap_cnt + 2'h1;
    end
    if (s_ff.strap_cnt == LOFPC_STRAP_WAIT) begin
      nxt_s.auto_x = s_ff.strap_s2;
    end

    // the inject request lasts one cycle, flipping one stream bit unless the self-test is idle
    if (s_ff.inject) begin
      nxt_s.inject = 1'b0;
    end

    // data phase of a write
    // only six low bits stored
    if (s_ff.wr_led) begin
      nxt_s.led = wdat[LOFPC_LED_FIELD_W-1:0];
    end
    if (s_ff.wr_ctl) begin
      nxt_s.auto_x = wdat[LOFPC_AUTO_X_BIT];
      nxt_s.force_x = wdat[LOFPC_FORCE_X_BIT];
      nxt_s.long_seq = wdat[LOFPC_LONG_SEQ_BIT];
      nxt_s.run = wdat[LOFPC_RUN_BIT];
      nxt_s.bypass = wdat[LOFPC_BYPASS_BIT];
      if (wdat[LOFPC_INJECT_BIT]) begin
        nxt_s.inject = 1'b1;
      end
    end

    // self-test: generator looped back into a self-syncing checker
    // sequence length select
    if (s_ff.long_seq) begin
      gen_fb = s_ff.gen[14] ^ s_ff.gen[13];
      chk_fb = s_ff.chk[14] ^ s_ff.chk[13];
      fill_max = LOFPC_FILL_LONG;
    end else begin
      gen_fb = s_ff.gen[8] ^ s_ff.gen[4];
      chk_fb = s_ff.chk[8] ^ s_ff.chk[4];
      fill_max = LOFPC_FILL_SHORT;
    end

    case (s_ff.bst)
      LOFPC_BIST_IDLE: begin
        nxt_s.tx_bit = 1'b0;
        nxt_s.gen = LOFPC_PRBS_SEED;
        nxt_s.fill = 5'h00;
        if (s_ff.run) begin
          nxt_s.bst = LOFPC_BIST_FILL;
        end
      end
      LOFPC_BIST_FILL, LOFPC_BIST_CHECK: begin
        nxt_s.gen = {s_ff.gen[13:0], gen_fb};
        nxt_s.tx_bit = gen_fb ^ s_ff.inject;
        nxt_s.chk = {s_ff.chk[13:0], s_ff.tx_bit};
        if (s_ff.bst == LOFPC_BIST_FILL) begin
          nxt_s.fill = s_ff.fill + 5'h01;
          if (s_ff.fill == fill_max) begin
            nxt_s.bst = LOFPC_BIST_CHECK;
          end
        end else if (s_ff.tx_bit != chk_fb) begin
          nxt_s.fail = 1'b1;
        end
        // a new sequence length needs a fresh fill
        if (s_ff.long_seq != nxt_s.long_seq) begin
          nxt_s.bst = LOFPC_BIST_FILL;
          nxt_s.fill = 5'h00;
        end
      end
      default: begin
        nxt_s.bst = LOFPC_BIST_IDLE;
      end
    endcase

    if (!s_ff.run) begin
      nxt_s.bst = LOFPC_BIST_IDLE;
      nxt_s.fail = 1'b0;
    end
    nxt_s.pass = (s_ff.bst == LOFPC_BIST_CHECK) && !nxt_s.fail && s_ff.run;

    for (int i = 0; i < 3; i++) begin
      if (raw[i]) begin
        nxt_s.str_cnt[i] = LOFPC_STRETCH_W'(STRETCH_CYCLES - 1);
      end else if (s_ff.str_cnt[i] != '0) begin
        nxt_s.str_cnt[i] = s_ff.str_cnt[i] - LOFPC_STRETCH_W'(1);
      end
      stretched = raw[i] || (s_ff.str_cnt[i] != '0);
      drive = s_ff.bypass ? raw[i] : stretched;
      if (s_ff.led[LOFPC_OVR_EN_LSB + i]) begin
        nxt_s.led_out[i] = s_ff.led[i];
      end else begin
        nxt_s.led_out[i] = drive;
      end
    end

    nxt_s.cross_sel = s_ff.force_x || (s_ff.auto_x && an.auto_swap_req);

    nxt_s.pause_rx = an.full_duplex &&
                     ((lp && rp) || (lp && la && !rp && ra));
    nxt_s.pause_tx = an.full_duplex &&
                     ((lp && rp) || (!lp && la && rp && ra));

    // address phase; read data taken from the values after any write
    nxt_s.wr_led = 1'b0;
    nxt_s.wr_ctl = 1'b0;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        nxt_s.wr_led = addr_ok && (haddr[7:2] == LOFPC_LED_FORCE_IDX);
        nxt_s.wr_ctl = addr_ok && (haddr[7:2] == LOFPC_XCVR_CTRL_IDX);
      end else begin
        nxt_s.rdata = 16'h0000;
        if (addr_ok && (haddr[7:2] == LOFPC_LED_FORCE_IDX)) begin
          nxt_s.rdata[LOFPC_LED_FIELD_W-1:0] = nxt_s.led;
        end else if (addr_ok && (haddr[7:2] == LOFPC_XCVR_CTRL_IDX)) begin
          nxt_s.rdata[LOFPC_AUTO_X_BIT] = nxt_s.auto_x;
          nxt_s.rdata[LOFPC_FORCE_X_BIT] = nxt_s.force_x;
          nxt_s.rdata[LOFPC_PAUSE_RX_BIT] = nxt_s.pause_rx;
          nxt_s.rdata[LOFPC_PAUSE_TX_BIT] = nxt_s.pause_tx;
          nxt_s.rdata[LOFPC_INJECT_BIT] = nxt_s.inject;
          nxt_s.rdata[LOFPC_LONG_SEQ_BIT] = nxt_s.long_seq;
          nxt_s.rdata[LOFPC_PASS_BIT] = nxt_s.pass;
          nxt_s.rdata[LOFPC_RUN_BIT] = nxt_s.run;
          nxt_s.rdata[LOFPC_BYPASS_BIT] = nxt_s.bypass;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
      s_ff.led <= LOFPC_LED_FORCE_RST;
      s_ff.gen <= LOFPC_PRBS_SEED;
      s_ff.bst <= LOFPC_BIST_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule // lofpc_regs

// ### testbench/lofpc_regs_properties.sv
`timescale 1ns/1ps
module lofpc_regs_properties
  import lofpc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // status and control outputs
  input wire lofpc_an_s an,
  input wire logic crossover_sel,
  input wire logic pause_rx_en,
  input wire logic pause_tx_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [1:0] l;
  logic [1:0] p;
  logic rx_x, tx_x, rd, rd_led, rd_ctl;
  assign l = an.local_ability_reg;
  assign p = an.partner_ability_reg;
  // bit 0 of each pair is symmetric pause, bit 1 the asymmetric direction
  assign rx_x = an.full_duplex & l[0] & (p[0] | l[1] & p[1]);
  assign tx_x = an.full_duplex & p[0] & (l[0] | l[1] & p[1]);
  assign rd = hsel & htrans[1] & !hwrite & hreadyout;
  assign rd_led = rd & (haddr == {24'h0, LOFPC_LED_FORCE_IDX, 2'h0});
  assign rd_ctl = rd & (haddr == {24'h0, LOFPC_XCVR_CTRL_IDX, 2'h0});
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or response not okay");
  chk_pause_rx: assert property (
    $past(rstn) |-> pause_rx_en == $past(rx_x))
    else $error("pause receive not resolved");
  chk_pause_tx: assert property (
    $past(rstn) |-> pause_tx_en == $past(tx_x))
    else $error("pause transmit not resolved");
  chk_half_dup: assert property (
    !an.full_duplex [*2] |-> !pause_rx_en && !pause_tx_en)
    else $error("pause enabled in half duplex");
  chk_led_upper: assert property (rd_led |=> hrdata[15:6] == 10'h0)
    else $error("led register upper bits not zero");
  chk_rd_upper: assert property (rd |=> hrdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  chk_force_cross: assert property (
    rd_ctl ##1 hrdata[14] |-> ##2 crossover_sel)
    else $error("forced crossover not applied");
  chk_stop_clear: assert property (
    rd_ctl ##1 !hrdata[8] |-> !hrdata[9])
    else $error("pass flag set while stopped");
endmodule // lofpc_regs_properties

bind lofpc_regs lofpc_regs_properties lofpc_regs_properties_i (.mclk, .rstn,
  .hsel, .haddr, .htrans, .hwrite, .hreadyout, .hresp, .hrdata, .an,
  .crossover_sel, .pause_rx_en, .pause_tx_en);

// ### testbench/lofpc_regs_tb.sv
`timescale 1ns/1ps
module lofpc_regs_tb;
  import lofpc_pkg::*;
  // short stretch keeps the run brief
  localparam int STR = 8;
  localparam logic [31:0] A_LED = {24'h0, LOFPC_LED_FORCE_IDX, 2'h0};
  localparam logic [31:0] A_CTL = {24'h0, LOFPC_XCVR_CTRL_IDX, 2'h0};
  logic mclk = 0, rstn = 0, hsel = 0, hwrite = 0;
  logic auto_crossover_strap = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, speed_led_out, link_led_out;
  logic activity_collision_led_out, crossover_sel, pause_rx_en;
  logic pause_tx_en, selftest_tx_bit, rx, tx;
  lofpc_ind_s ind = '0;
  lofpc_an_s an = '0;
  int mismatches = 0, n_compared = 0, cycles = 0;
  assign hready = hreadyout;
  always #2.5 mclk = ~mclk;
  lofpc_regs #(.STRETCH_CYCLES(STR)) lofpc_regs_i (.mclk, .rstn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .ind, .an, .auto_crossover_strap, .speed_led_out,
    .link_led_out, .activity_collision_led_out, .crossover_sel,
    .pause_rx_en, .pause_tx_en, .selftest_tx_bit);
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rc(input string s, input logic [31:0] a, input logic [31:0] e);
    xfer(0, a, 0);
    chk(s, e, rd);
  endtask
  // outputs sampled mid-cycle, clear of the launching edge
  task outs(input string s, input logic [5:0] e);
    @(negedge mclk);
    chk(s, {26'h0, e}, {26'h0, speed_led_out, link_led_out,
      activity_collision_led_out, crossover_sel, pause_rx_en, pause_tx_en});
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1;
    repeat (3) @(posedge mclk);
    rc("led reset", A_LED, 0);
    rc("ctl reset", A_CTL, 32'h8000);
    xfer(1, A_LED, 32'hffff);
    rc("led reserved", A_LED, 32'h3f);
    for (int i = 0; i < 3; i++) begin
      xfer(1, A_LED, 32'h9 << i);
      @(posedge mclk);
      outs("led force", 6'h8 << i);
    end
    xfer(1, A_LED, 32'h7);
    rc("led stored", A_LED, 32'h7);
    outs("led pins", 6'h0);
    $display("test led force done");
    xfer(1, A_CTL, 32'h80);
    @(posedge mclk);
    ind <= 3'h7;
    @(posedge mclk);
    ind <= 3'h0;
    outs("bypass on", 6'h38);
    outs("bypass off", 6'h0);
    xfer(1, A_CTL, 0);
    @(posedge mclk);
    ind <= 3'h7;
    @(posedge mclk);
    ind <= 3'h0;
    repeat (3) @(posedge mclk);
    outs("stretch hold", 6'h38);
    repeat (STR + 4) @(posedge mclk);
    outs("stretch end", 6'h0);
    ind <= 3'h7;
    xfer(1, A_LED, 32'h38);
    @(posedge mclk);
    outs("force low", 6'h0);
    ind <= 3'h0;
    xfer(1, A_LED, 0);
    $display("test led stretch done");
    an <= 6'h01;
    xfer(1, A_CTL, 32'h8000);
    repeat (2) @(posedge mclk);
    outs("auto cross", 6'h4);
    xfer(1, A_CTL, 0);
    repeat (2) @(posedge mclk);
    outs("auto off", 6'h0);
    an <= 6'h0;
    xfer(1, A_CTL, 32'h7200);
    rc("ctl read only", A_CTL, 32'h4000);
    outs("force cross", 6'h4);
    xfer(1, A_CTL, 0);
    $display("test crossover done");
    for (int k = 0; k < 32; k++) begin
      @(posedge mclk);
      an <= {k[4:0], 1'b0};
      rx = k[0] & k[3] & (k[1] | k[4] & k[2]);
      tx = k[0] & k[1] & (k[3] | k[4] & k[2]);
      rc("pause bits", A_CTL, {18'h0, rx, tx, 12'h0});
      outs("pause pins", {4'h0, rx, tx});
    end
    an <= 6'h0;
    $display("test pause done");
    xfer(1, A_CTL, 32'h500);
    repeat (40) @(posedge mclk);
    rc("bist long", A_CTL, 32'h700);
    xfer(1, A_CTL, 32'hd00);
    repeat (40) @(posedge mclk);
    rc("bist inject", A_CTL, 32'h500);
    xfer(1, A_CTL, 0);
    rc("bist stop", A_CTL, 0);
    xfer(1, A_CTL, 32'h100);
    repeat (30) @(posedge mclk);
    rc("bist short", A_CTL, 32'h300);
    $display("test selftest done");
    xfer(1, 32'h68, 32'hffff);
    rc("unmapped", 32'h68, 0);
    rc("ctl kept", A_CTL, 32'h300);
    $display("test unmapped done");
    finish_test;
  end
endmodule // lofpc_regs_tb
